// ===== jog_io_pkg.sv
// shared constants for the local jog mode i/o switch
package jog_io_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MP_FUNC = 8'h04;
    localparam logic [7:0] ADDR_STAT_SEL = 8'h08;
    localparam logic [7:0] ADDR_RAMP_EN = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    // ****************************************
    // field layout
    // ****************************************
    localparam int CTRL_PERMIT_GATE_BIT = 0;
    localparam int CTRL_SIX_AXIS_BIT = 1;
    localparam int MP_FUNC_W = 2;
    localparam int STAT_SEL_W = 5;
    localparam int STAT_AXIS_W = 3;
    localparam int NUM_AXES = 12;
    localparam int GROUP_AXES = 6;
    localparam int NUM_MP = 4;
    localparam int NUM_STAT_OUT = 4;
    localparam int STAT_SIGS = 4;
    localparam int SYNC_W = 9;
    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] MP_FN_NONE = 2'h0;
    localparam logic [1:0] MP_FN_SENSOR = 2'h1;
    localparam logic [1:0] MP_FN_SYNC = 2'h2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] MP_FUNC_RST = 8'h00;
    // per output {signal[1:0], axis[2:0]}; signal 0 is counter interrupt
    localparam logic [19:0] STAT_SEL_RST = 20'h08020;
    localparam logic [11:0] RAMP_EN_RST = 12'h000;
    localparam logic [3:0] NO_AXIS = 4'hF;
    typedef enum logic {MODE_BUS, MODE_JOG} mode_t;
endpackage : jog_io_pkg

// ===== sync_stage.sv
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module sync_stage #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // the first stage feeds the second stage only
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule : sync_stage

// ===== local_jog_mode_io_switch.sv
// special-purpose i/o switch: bus mode and local jog mode
//
// Notes on behaviour
// - select low enters local jog mode
// - select high returns to bus mode
// - device drives the jog permit output
// - permit high only after gating command
// - each multipurpose input: sensor or sync start
// - multipurpose inputs have no function after reset
// - jog mode: multipurpose inputs select jog axis
// - their functions off in jog mode
// - six-axis: upper select lines unused in bus
// - jog plus/minus drive only in jog mode
// - speed inputs are sensors of jog axis
// - ramp function: speed inputs give up/down/const
// - status outputs show chosen axis status
// - first status output resets to axis0 interrupt
// - second status output resets to axis1 interrupt
// - fixed input polarity, no filter setting
// - emergency stop halts every axis pulse
// - group-two stop halts second group only
`timescale 1ns/1ps
module local_jog_mode_io_switch
    import jog_io_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_local_jog_select_n,
    input wire logic i_jog_plus_command_n,
    input wire logic i_jog_minus_command_n,
    input wire logic i_speed_command_0_n,
    input wire logic i_speed_command_1_n,
    input wire logic [NUM_MP-1:0] i_multipurpose_input_n,
    input wire logic i_emergency_stop_all_n,
    input wire logic i_emergency_stop_group_two_n,
    input wire logic i_group_axis_reset_in_n,
    input wire logic [NUM_AXES*STAT_SIGS-1:0] i_axis_status,
    output logic o_jog_mode,
    output logic o_jog_permit_out,
    output logic [3:0] o_jog_axis,
    output logic o_jog_plus,
    output logic o_jog_minus,
    output logic [1:0] o_jog_sensor,
    output logic o_ramp_up,
    output logic o_ramp_down,
    output logic o_ramp_const,
    output logic [NUM_MP-1:0] o_mp_sensor,
    output logic [NUM_MP-1:0] o_mp_sync_start,
    output logic [NUM_STAT_OUT-1:0] o_status_output,
    output logic [NUM_AXES-1:0] o_pulse_stop,
    output logic o_group_axis_reset
);
    // ****************************************
    // registers
    // ****************************************
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic [7:0] mp_func_r;
    logic [7:0] mp_func_nxt;
    logic [19:0] stat_sel_r;
    logic [19:0] stat_sel_nxt;
    logic [11:0] ramp_en_r;
    logic [11:0] ramp_en_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    mode_t mode_r;
    mode_t mode_nxt;

    // ****************************************
    // input synchronisers
    // ****************************************
    // pins are active low and fixed; no polarity or filter register exists
    // the idle level of all synchronised pins is high
    logic [SYNC_W-1:0] raw_n;
    logic [SYNC_W-1:0] syn_n;
    assign raw_n = {i_multipurpose_input_n, i_speed_command_1_n, i_speed_command_0_n,
                    i_jog_minus_command_n, i_jog_plus_command_n, i_local_jog_select_n};

    sync_stage #(
        .W(SYNC_W),
        .RST_VAL({SYNC_W{1'b1}})
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_d(raw_n),
        .o_q(syn_n)
    );

    wire select_act = ~syn_n[0];
    wire plus_act = ~syn_n[1];
    wire minus_act = ~syn_n[2];
    wire ss0_act = ~syn_n[3];
    wire ss1_act = ~syn_n[4];
    wire [NUM_MP-1:0] mp_act = ~syn_n[8:5];

    // ****************************************
    // register bus decode
    // ****************************************
    wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    wire wr_mp = i_wr && (i_addr == ADDR_MP_FUNC);
    wire wr_stat = i_wr && (i_addr == ADDR_STAT_SEL);
    wire wr_ramp = i_wr && (i_addr == ADDR_RAMP_EN);
    wire permit_gate = ctrl_r[CTRL_PERMIT_GATE_BIT];
    wire six_axis = ctrl_r[CTRL_SIX_AXIS_BIT];

    assign ctrl_nxt = wr_ctrl ? i_wdata[1:0] : ctrl_r;
    assign mp_func_nxt = wr_mp ? i_wdata[7:0] : mp_func_r;
    assign stat_sel_nxt = wr_stat ? i_wdata[19:0] : stat_sel_r;
    assign ramp_en_nxt = wr_ramp ? i_wdata[11:0] : ramp_en_r;

    // ****************************************
    // mode switch
    // ****************************************
    // the mode follows the clean synchronised select, one edge per change
    assign mode_nxt = select_act ? MODE_JOG : MODE_BUS;
    wire jog = (mode_r == MODE_JOG);

    // ****************************************
    // axis select and jog commands
    // ****************************************
    // bus mode ignores upper lines on the six-axis board; in jog all four combine
    wire [3:0] sel_code = mp_act;
    wire axis_ok = six_axis ? (sel_code < 4'(GROUP_AXES)) : (sel_code < 4'(NUM_AXES));
    wire [3:0] axis_nxt = (jog && axis_ok) ? sel_code : NO_AXIS;
    wire axis_valid = (axis_nxt != NO_AXIS);
    wire ramp_fn = axis_valid && ramp_en_r[axis_nxt];

    // both directions together cancel, so no drive starts on a shorted switch
    wire plus_nxt = axis_valid && plus_act && !minus_act;
    wire minus_nxt = axis_valid && minus_act && !plus_act;
    wire [1:0] jsens_nxt = axis_valid ? {ss1_act, ss0_act} : 2'h0;
    wire up_nxt = ramp_fn && ss0_act && !ss1_act;
    wire down_nxt = ramp_fn && ss1_act && !ss0_act;
    wire const_nxt = ramp_fn && (ss0_act == ss1_act);

    // ****************************************
    // multipurpose input functions
    // ****************************************
    logic [NUM_MP-1:0] mps_nxt;
    logic [NUM_MP-1:0] mpy_nxt;
    logic [1:0] fn [NUM_MP];
    always_comb begin
        for (int k = 0; k < NUM_MP; k++) begin
            fn[k] = mp_func_r[k*MP_FUNC_W +: MP_FUNC_W];
            // upper lines have no bus-mode function on the six-axis board
            mps_nxt[k] = !jog && mp_act[k] && (fn[k] == MP_FN_SENSOR)
                         && !(six_axis && k >= 2);
            mpy_nxt[k] = !jog && mp_act[k] && (fn[k] == MP_FN_SYNC)
                         && !(six_axis && k >= 2);
        end
    end

    // ****************************************
    // status output routing
    // ****************************************
    logic [NUM_STAT_OUT-1:0] stat_nxt;
    logic [4:0] sel [NUM_STAT_OUT];
    logic [5:0] idx [NUM_STAT_OUT];
    always_comb begin
        for (int k = 0; k < NUM_STAT_OUT; k++) begin
            sel[k] = stat_sel_r[k*STAT_SEL_W +: STAT_SEL_W];
            // outputs 0,1 serve group one, outputs 2,3 group two
            idx[k] = 6'((k / 2) * GROUP_AXES * STAT_SIGS)
                     + 6'(sel[k][2:0] * STAT_SIGS) + 6'(sel[k][4:3]);
            stat_nxt[k] = (sel[k][2:0] < 3'(GROUP_AXES)) && i_axis_status[idx[k]];
            if (six_axis && k >= 2) begin
                stat_nxt[k] = 1'b0;
            end
        end
    end

    // ****************************************
    // emergency stops
    // ****************************************
    // stops skip the synchroniser so pulses halt one edge after the pin
    wire stop_all = ~i_emergency_stop_all_n;
    wire stop_two = ~i_emergency_stop_group_two_n && !six_axis;
    wire [NUM_AXES-1:0] stop_nxt = {{GROUP_AXES{stop_all | stop_two}},
                                    {GROUP_AXES{stop_all}}};

    // ****************************************
    // read data
    // ****************************************
    wire [31:0] state_word = {16'h0000, 3'h0, o_pulse_stop[0], o_pulse_stop[NUM_AXES-1],
                              o_ramp_up, o_ramp_down, o_ramp_const,
                              o_jog_axis, o_jog_minus, o_jog_plus,
                              o_jog_permit_out, o_jog_mode};
    // unmapped addresses read as zero
    assign rdata_nxt = !i_rd ? 32'h0 :
                       (i_addr == ADDR_CTRL) ? {30'h0, ctrl_r} :
                       (i_addr == ADDR_MP_FUNC) ? {24'h0, mp_func_r} :
                       (i_addr == ADDR_STAT_SEL) ? {12'h0, stat_sel_r} :
                       (i_addr == ADDR_RAMP_EN) ? {20'h0, ramp_en_r} :
                       (i_addr == ADDR_STATE) ? state_word : 32'h0;

    // ****************************************
    // state update
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RST;
            mp_func_r <= MP_FUNC_RST;
            stat_sel_r <= STAT_SEL_RST;
            ramp_en_r <= RAMP_EN_RST;
            rdata_r <= 32'h0;
            mode_r <= MODE_BUS;
        end else begin
            ctrl_r <= ctrl_nxt;
            mp_func_r <= mp_func_nxt;
            stat_sel_r <= stat_sel_nxt;
            ramp_en_r <= ramp_en_nxt;
            rdata_r <= rdata_nxt;
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_jog_mode <= 1'b0;
            o_jog_permit_out <= 1'b0;
            o_jog_axis <= NO_AXIS;
            o_jog_plus <= 1'b0;
            o_jog_minus <= 1'b0;
            o_jog_sensor <= 2'h0;
            o_ramp_up <= 1'b0;
            o_ramp_down <= 1'b0;
            o_ramp_const <= 1'b0;
        end else begin
            o_jog_mode <= jog;
            o_jog_permit_out <= permit_gate;
            o_jog_axis <= axis_nxt;
            o_jog_plus <= plus_nxt;
            o_jog_minus <= minus_nxt;
            o_jog_sensor <= jsens_nxt;
            o_ramp_up <= up_nxt;
            o_ramp_down <= down_nxt;
            o_ramp_const <= const_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_mp_sensor <= '0;
            o_mp_sync_start <= '0;
            o_status_output <= '0;
            o_pulse_stop <= '0;
            o_group_axis_reset <= 1'b0;
        end else begin
            o_mp_sensor <= mps_nxt;
            o_mp_sync_start <= mpy_nxt;
            o_status_output <= stat_nxt;
            o_pulse_stop <= stop_nxt;
            o_group_axis_reset <= ~i_group_axis_reset_in_n;
        end
    end

    assign o_rdata = rdata_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // two sync flops, the mode flop and the output flop: five samples of the pin
    a_jog_mode_entry: assert property (
        !i_local_jog_select_n [*5] |-> o_jog_mode)
        else $error("jog mode not entered after select low");
    a_bus_mode_return: assert property (
        i_local_jog_select_n [*5] |-> !o_jog_mode)
        else $error("bus mode not resumed after select high");
    a_permit_gated: assert property (
        o_jog_permit_out |-> $past(ctrl_r[CTRL_PERMIT_GATE_BIT]))
        else $error("permit high without gating command");
    a_permit_follows: assert property (
        wr_ctrl && i_wdata[CTRL_PERMIT_GATE_BIT] |-> ##2 o_jog_permit_out)
        else $error("permit not raised after gating command");
    a_mp_quiet_jog: assert property (
        o_jog_mode |-> (o_mp_sensor == '0) && (o_mp_sync_start == '0))
        else $error("multipurpose function active in jog mode");
    a_jog_bus_ignored: assert property (
        !o_jog_mode && $past(!o_jog_mode) |-> !o_jog_plus && !o_jog_minus)
        else $error("jog drive in bus mode");
    a_reset_no_func: assert property (
        $rose(i_rst_n) |-> mp_func_r == MP_FUNC_RST)
        else $error("multipurpose function set after reset");
    a_stat_reset: assert property (
        $rose(i_rst_n) |-> stat_sel_r == STAT_SEL_RST)
        else $error("status routing not at reset default");
    a_stop_all: assert property (
        !i_emergency_stop_all_n |=> o_pulse_stop == '1)
        else $error("emergency stop did not halt all axes");
    a_stop_group_two: assert property (
        i_emergency_stop_all_n && !i_emergency_stop_group_two_n && !six_axis
        |=> o_pulse_stop == {{GROUP_AXES{1'b1}}, {GROUP_AXES{1'b0}}})
        else $error("group two stop wrong axes");
    a_ramp_exclusive: assert property (
        (o_ramp_up || o_ramp_down || o_ramp_const)
        |-> $onehot0({o_ramp_up, o_ramp_down, o_ramp_const}) && o_jog_mode)
        else $error("ramp command outside jog or not exclusive");

    // outputs are registered from last cycle's settings, hence the $past terms
    a_axis_in_range: assert property (
        o_jog_axis != NO_AXIS |-> o_jog_mode && (o_jog_axis < 4'(NUM_AXES)))
        else $error("jog axis outside jog mode or out of range");
    a_six_axis_range: assert property (
        $past(six_axis) && (o_jog_axis != NO_AXIS) |-> o_jog_axis < 4'(GROUP_AXES))
        else $error("six-axis jog axis out of range");
    a_drive_needs_axis: assert property (
        o_jog_plus || o_jog_minus |-> (o_jog_axis != NO_AXIS) && !(o_jog_plus && o_jog_minus))
        else $error("jog drive without axis or both directions");
    a_sensor_bus_quiet: assert property (
        !o_jog_mode |-> o_jog_sensor == 2'h0)
        else $error("jog sensor active in bus mode");
    a_ramp_needs_axis: assert property (
        o_ramp_up || o_ramp_down || o_ramp_const |-> o_jog_axis != NO_AXIS)
        else $error("ramp command without jog axis");
    a_mp_upper_six: assert property (
        $past(six_axis) |-> (o_mp_sensor[3:2] == 2'h0) && (o_mp_sync_start[3:2] == 2'h0))
        else $error("upper lines active on six-axis board");
    a_mp_no_func: assert property (
        $past(mp_func_r) == MP_FUNC_RST |-> (o_mp_sensor == '0) && (o_mp_sync_start == '0))
        else $error("multipurpose output without a function");
    a_stat_upper_six: assert property (
        $past(six_axis) |-> o_status_output[3:2] == 2'h0)
        else $error("group two status output on six-axis board");
    a_permit_drop: assert property (
        wr_ctrl && !i_wdata[CTRL_PERMIT_GATE_BIT] |-> ##2 !o_jog_permit_out)
        else $error("permit stays high after gating cleared");
    a_stop_none: assert property (
        i_emergency_stop_all_n && i_emergency_stop_group_two_n |=> o_pulse_stop == '0)
        else $error("pulse stop without a stop input");

    c_jog_entered: cover property ($rose(o_jog_mode));
    c_six_axis_jog: cover property (o_jog_mode && $past(six_axis) && (o_jog_axis != NO_AXIS));
    c_jog_plus_drive: cover property (o_jog_mode && o_jog_plus);
    c_ramp_up: cover property (o_ramp_up);
    c_group_stop: cover property (o_pulse_stop == {{GROUP_AXES{1'b1}}, {GROUP_AXES{1'b0}}});
endmodule : local_jog_mode_io_switch

// ===== panel_model.sv
// operator panel model: jog switches, axis selector, stop and reset buttons
`timescale 1ns/1ps
module panel_model (
    input wire logic i_sys_clk,
    output logic o_sel_n,
    output logic o_plus_n,
    output logic o_minus_n,
    output logic [1:0] o_ss_n,
    output logic [3:0] o_lines_n,
    output logic o_stop_all_n,
    output logic o_stop_two_n,
    output logic o_grp_rst_n
);
    // ****************************************
    // contacts
    // ****************************************
    // plain contacts with pull-ups, so a released switch reads high
    logic [11:0] pins_n_r = 12'hFFF;
    assign {o_grp_rst_n, o_stop_two_n, o_stop_all_n, o_lines_n, o_ss_n, o_minus_n, o_plus_n,
        o_sel_n} = pins_n_r;
    // press the set bits and release the rest just after an edge
    task automatic drive(input logic [11:0] press);
        @(posedge i_sys_clk);
        pins_n_r <= ~press;
    endtask : drive
endmodule : panel_model

// ===== local_jog_mode_io_switch_tb_top.sv
// self-checking testbench for the local jog mode i/o switch
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: line %0d", $time, `__LINE__); end end
module local_jog_mode_io_switch_tb_top
    import jog_io_pkg::*;
;
    localparam logic [11:0] SEL = 12'h001;
    localparam logic [11:0] PLS = 12'h002;
    localparam logic [11:0] MNS = 12'h004;
    localparam logic [11:0] SS0 = 12'h008;
    localparam logic [11:0] SS1 = 12'h010;
    localparam logic [11:0] STP = 12'h200;
    localparam logic [11:0] ST2 = 12'h400;
    localparam logic [11:0] GRS = 12'h800;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [47:0] i_axis_status = 48'h000000000000;
    logic sel_n, plus_n, minus_n, stop_n, stop2_n, grst_n;
    logic [1:0] ss_n;
    logic [3:0] lines_n;
    logic [31:0] o_rdata;
    logic o_jog_mode, o_jog_permit_out, o_jog_plus, o_jog_minus, o_group_axis_reset;
    logic o_ramp_up, o_ramp_down, o_ramp_const;
    logic [3:0] o_jog_axis, o_mp_sensor, o_mp_sync_start, o_status_output;
    logic [1:0] o_jog_sensor;
    logic [11:0] o_pulse_stop;
    int mismatches = 0;
    int samples_checked = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    panel_model pnl (
        .i_sys_clk, .o_sel_n(sel_n), .o_plus_n(plus_n), .o_minus_n(minus_n), .o_ss_n(ss_n),
        .o_lines_n(lines_n), .o_stop_all_n(stop_n), .o_stop_two_n(stop2_n),
        .o_grp_rst_n(grst_n)
    );
    local_jog_mode_io_switch DUT (
        .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_local_jog_select_n(sel_n), .i_jog_plus_command_n(plus_n),
        .i_jog_minus_command_n(minus_n), .i_speed_command_0_n(ss_n[0]),
        .i_speed_command_1_n(ss_n[1]), .i_multipurpose_input_n(lines_n),
        .i_emergency_stop_all_n(stop_n), .i_emergency_stop_group_two_n(stop2_n),
        .i_group_axis_reset_in_n(grst_n), .i_axis_status, .o_jog_mode, .o_jog_permit_out,
        .o_jog_axis, .o_jog_plus, .o_jog_minus, .o_jog_sensor, .o_ramp_up, .o_ramp_down,
        .o_ramp_const, .o_mp_sensor, .o_mp_sync_start, .o_status_output, .o_pulse_stop,
        .o_group_axis_reset
    );
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [11:0] ax(input logic [3:0] a);
        return {3'h0, a, 5'h00};
    endfunction : ax
    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask : rd_chk
    // pins are synchronised first, so give them time to reach the outputs
    task automatic pins(input logic [11:0] c);
        pnl.drive(c);
        idle(6);
    endtask : pins
    task automatic stat(input logic [47:0] s);
        @(posedge i_sys_clk);
        i_axis_status <= s;
        idle(2);
    endtask : stat
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        `CHK(o_jog_axis, NO_AXIS)
        `CHK({o_jog_mode, o_jog_permit_out, o_pulse_stop}, 14'h0000)
        rd_chk(ADDR_CTRL, 32'h00000000);
        rd_chk(ADDR_MP_FUNC, 32'h00000000);
        rd_chk(ADDR_STAT_SEL, {12'h000, STAT_SEL_RST});
        rd_chk(ADDR_RAMP_EN, 32'h00000000);
        wr(8'h14, 32'hFFFFFFFF);
        rd_chk(8'h14, 32'h00000000);
        stat(48'h000010000001);
        `CHK(o_status_output, 4'h9)
        stat(48'h000001000010);
        `CHK(o_status_output, 4'h6)
    endtask : t_reset
    task automatic t_permit;
        wr(ADDR_CTRL, 32'h00000001);
        idle(1);
        `CHK(o_jog_permit_out, 1'b1)
        rd_chk(ADDR_CTRL, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000000);
        idle(1);
        `CHK(o_jog_permit_out, 1'b0)
    endtask : t_permit
    task automatic t_mode;
        pnl.drive(SEL);
        idle(2);
        `CHK(o_jog_mode, 1'b0)
        idle(3);
        `CHK(o_jog_mode, 1'b1)
        pins(12'h000);
        `CHK(o_jog_mode, 1'b0)
    endtask : t_mode
    task automatic t_mp;
        pins(ax(4'hF));
        `CHK({o_mp_sensor, o_mp_sync_start}, 8'h00)
        wr(ADDR_MP_FUNC, 32'h00000099);
        idle(3);
        `CHK({o_mp_sensor, o_mp_sync_start}, 8'h5A)
        pins(SEL | ax(4'hF));
        `CHK({o_mp_sensor, o_mp_sync_start, o_jog_axis}, 12'h00F)
        pins(ax(4'hF));
        `CHK({o_mp_sensor, o_mp_sync_start}, 8'h5A)
        wr(ADDR_CTRL, 32'h00000002);
        idle(3);
        `CHK({o_mp_sensor, o_mp_sync_start}, 8'h12)
        wr(ADDR_CTRL, 32'h00000000);
        rd_chk(ADDR_MP_FUNC, 32'h00000099);
    endtask : t_mp
    task automatic t_jog;
        wr(ADDR_RAMP_EN, 32'h00000020);
        pins(SEL | ax(4'h5) | PLS);
        `CHK({o_jog_axis, o_jog_plus, o_jog_minus}, 6'h16)
        rd_chk(ADDR_STATE, 32'h00000155);
        pins(SEL | ax(4'h5) | PLS | MNS);
        `CHK({o_jog_plus, o_jog_minus}, 2'h0)
        pins(SEL | ax(4'h5) | SS0);
        `CHK({o_jog_sensor, o_ramp_up, o_ramp_down, o_ramp_const}, 5'h0C)
        pins(SEL | ax(4'h5) | SS1);
        `CHK({o_jog_sensor, o_ramp_up, o_ramp_down, o_ramp_const}, 5'h12)
        pins(SEL | ax(4'h5) | SS0 | SS1);
        `CHK({o_jog_sensor, o_ramp_up, o_ramp_down, o_ramp_const}, 5'h19)
        pins(SEL | ax(4'hC) | PLS);
        `CHK({o_jog_axis, o_jog_plus}, 5'h1E)
        wr(ADDR_CTRL, 32'h00000002);
        pins(SEL | ax(4'h7) | PLS);
        `CHK({o_jog_axis, o_jog_plus}, 5'h1E)
        pins(SEL | ax(4'h3) | MNS);
        `CHK({o_jog_axis, o_jog_minus}, 5'h07)
        wr(ADDR_CTRL, 32'h00000000);
        pins(ax(4'h5) | PLS | SS0);
        `CHK({o_jog_mode, o_jog_plus, o_jog_sensor, o_ramp_up}, 5'h00)
    endtask : t_jog
    task automatic t_status;
        wr(ADDR_STAT_SEL, 32'h00003013);
        stat(48'h020000004000);
        `CHK(o_status_output, 4'h5)
        rd_chk(ADDR_STAT_SEL, 32'h00003013);
    endtask : t_status
    task automatic t_stop;
        pnl.drive(STP);
        idle(1);
        `CHK(o_pulse_stop, 12'hFFF)
        rd_chk(ADDR_STATE, 32'h000018F0);
        pins(SEL | STP);
        `CHK(o_pulse_stop, 12'hFFF)
        pins(ST2);
        `CHK(o_pulse_stop, 12'hFC0)
        pins(GRS);
        `CHK({o_group_axis_reset, o_pulse_stop}, 13'h1000)
        wr(ADDR_CTRL, 32'h00000002);
        pins(ST2);
        `CHK(o_pulse_stop, 12'h000)
        wr(ADDR_CTRL, 32'h00000000);
    endtask : t_stop
    task automatic end_of_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        #1;
        t_reset();
        t_permit();
        t_mode();
        t_mp();
        t_jog();
        t_status();
        t_stop();
        end_of_test();
    end
    // whole run takes well under 1000 cycles; the watchdog cuts a hang off after 20000 cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        end_of_test();
    end
endmodule : local_jog_mode_io_switch_tb_top
